// ### hdl/rtcs_device.sv
// device end of the rtc four-wire serial port
// How it works
// - sclk low at ce rise: out rise, in fall
// - sclk high at ce rise: out fall, in rise
// - ce frames session; ce low resets state
// - traffic moves in whole eight-bit bytes
// - control high nibble loads address pointer
// - control low nibble stores transfer format
// - every byte shifts msb first
// - format 8h writes exactly one byte
// - after single write, next byte is control
// - format 0h burst write, pointer wraps
// - burst write ends only at ce fall
// - format ch reads exactly one byte
// - after single read, next byte is control
// - format 4h burst read, pointer wraps
// - burst read ends only at ce fall
// - single reads and writes mix freely
// - nibble decode 8h, 0h, ch, 4h
// - hold seconds carry while ce high, for at most HOLD_CYC cycles
// - host waits 31 us before time access
// - host keeps ce low 62 us
`include "rtcs_consts.svh"

module rtcs_device
  import rtcs_pkg::*;
#(
  parameter int unsigned HOLD_CYC = `RTCS_HOLD_S * `RTCS_CLK_MHZ * `RTCS_US_PER_S
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // serial link
  rtcs_if.dev             link,
  // register file side
  output logic      [3:0] reg_addr,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic      [3:0] reg_waddr,
  output logic      [7:0] reg_wdata,
  // seconds carry
  input  wire logic       carry_in,
  output logic            carry_out
);

  logic [2:0]      pin_lvl;
  logic [2:0]      pin_rise;
  logic [2:0]      pin_fall;
  logic            ce_lvl;
  logic            ce_rise;
  logic            si_lvl;
  logic            sample_edge;
  logic            launch_edge;
  logic            byte_done;
  logic [7:0]      rx_byte;
  rtcs_dev_state_t state_reg;
  logic            cpol_reg;
  logic [2:0]      bit_cnt_reg;
  logic [7:0]      rx_reg;
  logic [7:0]      tx_reg;
  logic [3:0]      addr_reg;
  logic            burst_reg;
  logic            load_pend_reg;
  logic            so_reg;
  logic            so_oe_n_reg;
  logic            reg_wr_reg;
  logic [3:0]      reg_waddr_reg;
  logic [7:0]      reg_wdata_reg;
  logic            held_reg;
  logic [31:0]     hold_cnt_reg;
  logic            carry_out_reg;
  logic            release_carry;

  // pins come from the host's domain: ce, sclk and si share one delay
  rtcs_sync #(.W(3)) u_pin_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({link.ce, link.sclk, link.si}),
    .lvl  (pin_lvl),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  assign ce_lvl      = pin_lvl[2];
  assign ce_rise     = pin_rise[2];
  assign si_lvl      = pin_lvl[0];
  assign sample_edge = cpol_reg ? pin_rise[1] : pin_fall[1];
  assign launch_edge = cpol_reg ? pin_fall[1] : pin_rise[1];
  assign rx_byte     = {rx_reg[6:0], si_lvl};
  assign byte_done   = sample_edge && (bit_cnt_reg == `RTCS_BIT_LAST)
                       && (state_reg != DS_IDLE);

  // clock phase is fixed for the whole session at ce rise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cpol_reg <= 1'b0;
    else if (ce_rise)
      cpol_reg <= pin_lvl[1];
  end

  // session sequencing
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_reg <= DS_IDLE;
    else if (!ce_lvl)
      state_reg <= DS_IDLE;
    else if (ce_rise)
      state_reg <= DS_CTRL;
    else if (byte_done)
    begin
      unique case (state_reg)
        DS_CTRL:
          state_reg <= rtcs_decode(rx_byte[`RTCS_CTRL_FMT]);
        DS_WRITE:
          if (!burst_reg)
            state_reg <= DS_CTRL;
        DS_READ:
          if (!burst_reg)
            state_reg <= DS_CTRL;
        DS_IDLE,
        DS_NOP:
          state_reg <= state_reg;
      endcase
    end
  end

  // bit counting, a partial byte is dropped at ce fall
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bit_cnt_reg <= `RTCS_BIT_FIRST;
    else if (!ce_lvl || ce_rise)
      bit_cnt_reg <= `RTCS_BIT_FIRST;
    else if (sample_edge)
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_reg <= 8'h00;
    else if (sample_edge)
      rx_reg <= rx_byte;
  end

  // address pointer and burst flag
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_reg  <= 4'h0;
      burst_reg <= 1'b0;
    end
    else if (byte_done)
    begin
      if (state_reg == DS_CTRL)
      begin
        addr_reg  <= rx_byte[`RTCS_CTRL_ADDR];
        burst_reg <= rtcs_is_burst(rx_byte[`RTCS_CTRL_FMT]);
      end
      else if (burst_reg && (state_reg == DS_WRITE || state_reg == DS_READ))
        addr_reg <= rtcs_next_addr(addr_reg);
    end
  end

  // write strobe carries its own address, the pointer may already have moved
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_wr_reg    <= 1'b0;
      reg_waddr_reg <= 4'h0;
      reg_wdata_reg <= 8'h00;
    end
    else
    begin
      reg_wr_reg <= byte_done && (state_reg == DS_WRITE);
      if (byte_done && state_reg == DS_WRITE)
      begin
        reg_waddr_reg <= addr_reg;
        reg_wdata_reg <= rx_byte;
      end
    end
  end

  // read data is fetched one cycle after the pointer settles
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      load_pend_reg <= 1'b0;
    else
      load_pend_reg <= byte_done && ce_lvl
                       && ((state_reg == DS_CTRL
                            && rtcs_decode(rx_byte[`RTCS_CTRL_FMT]) == DS_READ)
                           || (state_reg == DS_READ && burst_reg));
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tx_reg <= 8'h00;
    else if (load_pend_reg)
      tx_reg <= reg_rdata;
    else if (launch_edge && state_reg == DS_READ)
      tx_reg <= {tx_reg[6:0], 1'b0};
  end

  // output driver, released outside read bytes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      so_reg      <= 1'b1;
      so_oe_n_reg <= 1'b1;
    end
    else if (!ce_lvl)
    begin
      so_reg      <= 1'b1;
      so_oe_n_reg <= 1'b1;
    end
    else if (byte_done && state_reg == DS_READ && !burst_reg)
      so_oe_n_reg <= 1'b1;
    else if (launch_edge && state_reg == DS_READ)
    begin
      so_reg      <= tx_reg[`RTCS_MSB];
      so_oe_n_reg <= 1'b0;
    end
  end

  // seconds carry held while the host reads or writes time
  assign release_carry = held_reg
                         && (!ce_lvl || hold_cnt_reg >= HOLD_CYC - 32'd1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      held_reg <= 1'b0;
    else if (carry_in && ce_lvl)
      held_reg <= 1'b1;
    else if (release_carry)
      held_reg <= 1'b0;
  end

  // the hold is capped so a stuck host cannot stop the clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hold_cnt_reg <= 32'h0000_0000;
    else if (!held_reg || !ce_lvl)
      hold_cnt_reg <= 32'h0000_0000;
    else
      hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      carry_out_reg <= 1'b0;
    else
      carry_out_reg <= (carry_in && !ce_lvl) || release_carry;
  end

  assign link.so_out  = so_reg;
  assign link.so_oe_n = so_oe_n_reg;
  assign reg_addr     = addr_reg;
  assign reg_wr       = reg_wr_reg;
  assign reg_waddr    = reg_waddr_reg;
  assign reg_wdata    = reg_wdata_reg;
  assign carry_out    = carry_out_reg;

endmodule

// ### hdl/rtcs_host.sv
// host end of the rtc four-wire serial port
`include "rtcs_consts.svh"

module rtcs_host
  import rtcs_pkg::*;
#(
  parameter int unsigned GUARD_CYC = `RTCS_GUARD_US * `RTCS_CLK_MHZ,
  parameter int unsigned GAP_CYC   = `RTCS_GAP_US * `RTCS_CLK_MHZ
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // serial link
  rtcs_if.host            link,
  // operation request
  input  wire logic       op_valid,
  input  rtcs_op_t        op_code,
  input  wire logic       op_cpol,
  input  wire logic [7:0] op_wdata,
  output logic            op_ready,
  // byte answer
  output logic            rsp_valid,
  output logic      [7:0] rsp_rdata
);

  rtcs_host_state_t state_reg;
  logic [15:0]      cnt_reg;
  logic [4:0]       tog_reg;
  logic             ce_reg;
  logic             sclk_reg;
  logic             si_reg;
  logic [7:0]       tx_reg;
  logic [7:0]       rx_reg;
  logic             ready_reg;
  logic             rsp_valid_reg;
  logic [7:0]       rsp_rdata_reg;
  logic             so_lvl;
  logic             take;
  logic             half_up;

  rtcs_sync #(.W(1)) u_so_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (link.so_line),
    .lvl  (so_lvl),
    .rise (),
    .fall ()
  );

  assign take    = op_valid && ready_reg;
  assign half_up = (cnt_reg == `RTCS_SCLK_HALF - 16'h0001);

  // sequencing, link pins and the ready handshake
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= HS_IDLE;
      cnt_reg   <= `RTCS_CNT_ZERO;
      tog_reg   <= `RTCS_TOG_FIRST;
      ce_reg    <= 1'b0;
      sclk_reg  <= 1'b0;
      ready_reg <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 16'h0001;
      unique case (state_reg)
        HS_IDLE:
          if (take && op_code == OP_OPEN)
          begin
            sclk_reg  <= op_cpol; // idle level set before ce rises
            cnt_reg   <= `RTCS_CNT_ZERO;
            ready_reg <= 1'b0;
            state_reg <= HS_SETUP;
          end
        HS_SETUP:
          if (half_up)
          begin
            ce_reg    <= 1'b1;
            cnt_reg   <= `RTCS_CNT_ZERO;
            state_reg <= HS_GUARD;
          end
        HS_GUARD:
          if (cnt_reg == 16'(GUARD_CYC - 1))
          begin
            ready_reg <= 1'b1;
            state_reg <= HS_READY;
          end
        HS_READY:
          if (take && op_code == OP_BYTE)
          begin
            cnt_reg   <= `RTCS_CNT_ZERO;
            tog_reg   <= `RTCS_TOG_FIRST;
            ready_reg <= 1'b0;
            state_reg <= HS_SHIFT;
          end
          else if (take && op_code == OP_CLOSE)
          begin
            ce_reg    <= 1'b0;
            cnt_reg   <= `RTCS_CNT_ZERO;
            ready_reg <= 1'b0;
            state_reg <= HS_GAP;
          end
        HS_SHIFT:
          if (half_up)
          begin
            sclk_reg <= ~sclk_reg;
            cnt_reg  <= `RTCS_CNT_ZERO;
            tog_reg  <= tog_reg + 5'h01;
            if (tog_reg == `RTCS_TOG_LAST)
            begin
              ready_reg <= 1'b1;
              state_reg <= HS_READY;
            end
          end
        HS_GAP:
          if (cnt_reg == 16'(GAP_CYC - 1))
          begin
            ready_reg <= 1'b1;
            state_reg <= HS_IDLE;
          end
      endcase
    end
  end

  // data: launch on even toggles, capture on odd ones, sixteen per byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      si_reg        <= 1'b0;
      tx_reg        <= 8'h00;
      rx_reg        <= 8'h00;
      rsp_valid_reg <= 1'b0;
      rsp_rdata_reg <= 8'h00;
    end
    else
    begin
      rsp_valid_reg <= 1'b0;
      if (state_reg == HS_READY && take && op_code == OP_BYTE)
        tx_reg <= op_wdata;
      else if (state_reg == HS_SHIFT && half_up)
      begin
        if (!tog_reg[0])
        begin
          si_reg <= tx_reg[`RTCS_MSB];
          tx_reg <= {tx_reg[6:0], 1'b0};
        end
        else
          rx_reg <= {rx_reg[6:0], so_lvl};
        if (tog_reg == `RTCS_TOG_LAST)
        begin
          rsp_valid_reg <= 1'b1;
          rsp_rdata_reg <= {rx_reg[6:0], so_lvl};
        end
      end
    end
  end

  assign link.ce   = ce_reg;
  assign link.sclk = sclk_reg;
  assign link.si   = si_reg;
  assign op_ready  = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rsp_rdata_reg;

endmodule

// ### hdl/rtcs_sync.sv
// two-flop synchroniser with edge detection on the settled level
module rtcs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // pins in
  input  wire logic [W-1:0] din,
  // synchronised level and edges
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  // meta_reg feeds only sync_reg
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= din;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign lvl  = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;

endmodule

// ### inc/rtcs_consts.svh
// named constants for the rtc four-wire serial port
`ifndef RTCS_CONSTS_SVH
`define RTCS_CONSTS_SVH

// transfer-format codes
`define RTCS_FMT_WR_ONE    4'h8
`define RTCS_FMT_WR_BURST  4'h0
`define RTCS_FMT_RD_ONE    4'hc
`define RTCS_FMT_RD_BURST  4'h4

// control byte fields and byte framing
`define RTCS_CTRL_ADDR     7:4
`define RTCS_CTRL_FMT      3:0
`define RTCS_MSB           7
`define RTCS_BIT_LAST      3'h7
`define RTCS_BIT_FIRST     3'h0
`define RTCS_ADDR_STEP     4'h1

// timing, clock in mhz, times in their own units
`define RTCS_CLK_MHZ       200
`define RTCS_GUARD_US      31
`define RTCS_GAP_US        62
`define RTCS_HOLD_S        1
`define RTCS_US_PER_S      1000000
`define RTCS_SCLK_HALF     16'h0008
`define RTCS_TOG_LAST      5'h0f
`define RTCS_TOG_FIRST     5'h00
`define RTCS_CNT_ZERO      16'h0000

`endif

// ### inc/rtcs_if.sv
// link wires between the serial host and the rtc serial port
interface rtcs_if;
  logic ce;
  logic sclk;
  logic si;
  logic so_out;
  logic so_oe_n;
  logic so_line;

  // released data-out line reads high, as with a pull-up
  assign so_line = so_oe_n ? 1'b1 : so_out;

  modport dev (input ce, input sclk, input si, output so_out, output so_oe_n);
  modport host (output ce, output sclk, output si, input so_line);
endinterface

// ### inc/rtcs_pkg.sv
// types and helper functions for the rtc four-wire serial port
`include "rtcs_consts.svh"

package rtcs_pkg;

  typedef enum logic [2:0] {DS_IDLE, DS_CTRL, DS_WRITE, DS_READ, DS_NOP} rtcs_dev_state_t;

  typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_GUARD, HS_READY, HS_SHIFT, HS_GAP}
    rtcs_host_state_t;

  typedef enum logic [1:0] {OP_OPEN, OP_BYTE, OP_CLOSE} rtcs_op_t;

  // pointer step, wraps from fh to 0h by width
  function automatic logic [3:0] rtcs_next_addr(input logic [3:0] addr);
    return addr + `RTCS_ADDR_STEP;
  endfunction

  // format nibble to session state
  function automatic rtcs_dev_state_t rtcs_decode(input logic [3:0] fmt);
    rtcs_dev_state_t st;
    st = DS_NOP;
    if (fmt == `RTCS_FMT_WR_ONE || fmt == `RTCS_FMT_WR_BURST)
      st = DS_WRITE;
    else if (fmt == `RTCS_FMT_RD_ONE || fmt == `RTCS_FMT_RD_BURST)
      st = DS_READ;
    return st;
  endfunction

  function automatic logic rtcs_is_burst(input logic [3:0] fmt);
    return (fmt == `RTCS_FMT_WR_BURST) || (fmt == `RTCS_FMT_RD_BURST);
  endfunction

endpackage

// ### sim/rtcs_link_properties.sv
// concurrent checks on the link wires between host and device ends
module rtcs_link_properties #(
  parameter int unsigned GUARD_CYC = 20,
  parameter int unsigned GAP_CYC   = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link wires
  input wire logic ce,
  input wire logic sclk,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe_n,
  input wire logic so_line
);
  timeunit 1ns;
  timeprecision 100ps;

  logic        ce_reg;
  logic        sclk_reg;
  logic        cpol_reg;
  logic [15:0] lo_cnt_reg;
  logic [15:0] hi_cnt_reg;
  logic [3:0]  launch_cnt_reg;
  logic        launch;

  // launch edge moves sclk away from the idle level latched at ce rise
  assign launch = (sclk != sclk_reg) && (sclk != cpol_reg);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ce_reg   <= 1'b0;
      sclk_reg <= 1'b0;
      cpol_reg <= 1'b0;
    end
    else
    begin
      ce_reg   <= ce;
      sclk_reg <= sclk;
      if (ce && !ce_reg)
        cpol_reg <= sclk;
    end
  end

  // counters saturate so a long idle never wraps into a false short gap
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lo_cnt_reg     <= 16'hffff;
      hi_cnt_reg     <= 16'h0000;
      launch_cnt_reg <= 4'hf;
    end
    else
    begin
      lo_cnt_reg     <= ce ? 16'h0000 : lo_cnt_reg + {15'h0000, lo_cnt_reg != 16'hffff};
      hi_cnt_reg     <= !ce ? 16'h0000 : hi_cnt_reg + {15'h0000, hi_cnt_reg != 16'hffff};
      launch_cnt_reg <= launch ? 4'h0 : launch_cnt_reg + {3'h0, launch_cnt_reg != 4'hf};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_half;
    ##1 $stable(sclk) [*7];
  endsequence

  sequence s_sclk_move;
    ce && (sclk != $past(sclk));
  endsequence

  a_idle_released: assert property (!ce [*6] |-> so_oe_n)
    else $error("data out driven while chip enable low");
  a_drive_at_launch: assert property ($fell(so_oe_n) |-> ce && launch_cnt_reg <= 4'h7)
    else $error("data out enabled away from a launch edge");
  a_so_on_launch: assert property
    ((!so_oe_n && $past(!so_oe_n) && so_out != $past(so_out)) |-> launch_cnt_reg <= 4'h7)
    else $error("data out changed away from a launch edge");
  a_half_period: assert property (s_sclk_move |-> s_half)
    else $error("serial clock half period too short");
  a_si_on_launch: assert property
    ((ce && $past(ce) && $changed(si)) |-> launch)
    else $error("serial in changed off the launch edge");
  a_close_at_idle: assert property ($fell(ce) |-> sclk == cpol_reg)
    else $error("session closed inside a byte");
  a_cpol_setup: assert property ($rose(ce) |-> $past(sclk, 7) == sclk)
    else $error("serial clock not settled at chip enable rise");
  a_guard_wait: assert property (s_sclk_move |-> hi_cnt_reg >= GUARD_CYC)
    else $error("clocking began before the guard time");
  a_gap_wait: assert property ($rose(ce) |-> lo_cnt_reg >= GAP_CYC)
    else $error("chip enable gap between sessions too short");
  a_line_resolve: assert property (!so_oe_n |-> so_line == so_out)
    else $error("data line differs from driven value");
endmodule

// ### sim/tb_rtcs_four_wire_serial_port.sv
// self-checking bench: host end drives device end across the link
module tb_rtc_four_wire_serial_port;
  timeunit 1ns;
  timeprecision 100ps;
  import rtcs_pkg::*;

  logic       clk;
  logic       rst;
  logic       op_valid;
  rtcs_op_t   op_code;
  logic       op_cpol;
  logic [7:0] op_wdata;
  logic       op_ready;
  logic       rsp_valid;
  logic [7:0] rsp_rdata;
  logic [3:0] reg_addr;
  logic [7:0] reg_rdata;
  logic       reg_wr;
  logic [3:0] reg_waddr;
  logic [7:0] reg_wdata;
  logic       carry_in;
  logic       carry_out;
  logic [7:0] regs [16];
  logic [7:0] wr_cnt;
  logic [7:0] cy_cnt;
  logic [7:0] rv_cnt;
  int         errors;
  int         n_tests;

  rtcs_if link();

  rtcs_device #(.HOLD_CYC(200)) rtcs_device_i (.clk(clk), .rst(rst), .link(link),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata), .carry_in(carry_in), .carry_out(carry_out));

  rtcs_host #(.GUARD_CYC(20), .GAP_CYC(40)) rtcs_host_i (.clk(clk), .rst(rst), .link(link),
    .op_valid(op_valid), .op_code(op_code), .op_cpol(op_cpol), .op_wdata(op_wdata),
    .op_ready(op_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

  rtcs_link_properties #(.GUARD_CYC(20), .GAP_CYC(40)) rtcs_link_properties_i (.clk(clk),
    .rst(rst), .ce(link.ce), .sclk(link.sclk), .si(link.si), .so_out(link.so_out),
    .so_oe_n(link.so_oe_n), .so_line(link.so_line));

  // register file answers in the same cycle, as the device expects
  assign reg_rdata = regs[reg_addr];

  function automatic logic [7:0] ival(input int i);
    return 8'ha0 ^ 8'(i);
  endfunction

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 16; i++)
        regs[i] <= ival(i);
      wr_cnt <= 8'h00;
      cy_cnt <= 8'h00;
      rv_cnt <= 8'h00;
    end
    else
    begin
      if (reg_wr === 1'b1)
      begin
        regs[reg_waddr] <= reg_wdata;
        wr_cnt          <= wr_cnt + 8'h01;
      end
      if (carry_out === 1'b1)
        cy_cnt <= cy_cnt + 8'h01;
      // one answer pulse per byte: a longer pulse shows up as an extra count
      if (rsp_valid === 1'b1)
        rv_cnt <= rv_cnt + 8'h01;
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    while (op_ready !== 1'b1 && k < 30000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 30000)
      chk8(8'h00, 8'h01);
  endtask

  // one host request, held until taken, then waits for completion
  task automatic op(input rtcs_op_t c, input logic p, input logic [7:0] d);
    wait_ready();
    op_code  = c;
    op_cpol  = p;
    op_wdata = d;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    @(negedge clk);
    wait_ready();
  endtask

  task automatic byte_io(input logic [7:0] d, input logic [7:0] exp);
    op(OP_BYTE, 1'b0, d);
    chk8(rsp_rdata, exp);
  endtask

  task automatic pulse_carry();
    carry_in = 1'b1;
    @(negedge clk);
    carry_in = 1'b0;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial
  begin
    rst      = 1'b1;
    op_valid = 1'b0;
    op_code  = OP_OPEN;
    op_cpol  = 1'b0;
    op_wdata = 8'h00;
    carry_in = 1'b0;
    errors   = 0;
    n_tests  = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    // idle-low clock: single writes, reads and a read-modify-write
    op(OP_OPEN, 1'b0, 8'h00);
    byte_io(8'h58, 8'hff);
    byte_io(8'h3c, 8'hff);
    byte_io(8'h78, 8'hff);
    byte_io(8'h77, 8'hff);
    byte_io(8'h5c, 8'hff);
    byte_io(8'h00, 8'h3c);
    byte_io(8'h58, 8'hff);
    byte_io(8'hc5, 8'hff);
    op(OP_CLOSE, 1'b0, 8'h00);
    chk8(regs[5], 8'hc5);
    chk8(regs[7], 8'h77);
    chk8(wr_cnt, 8'h03);
    // idle-high clock: burst write wraps, control-like data is stored
    op(OP_OPEN, 1'b1, 8'h00);
    byte_io(8'he0, 8'hff);
    for (int i = 0; i < 4; i++)
      byte_io(8'h18 + 8'(i * 16), 8'hff);
    op(OP_CLOSE, 1'b0, 8'h00);
    for (int i = 0; i < 4; i++)
      chk8(regs[(14 + i) % 16], 8'h18 + 8'(i * 16));
    chk8(regs[3], ival(3));
    // burst read across the wrap
    op(OP_OPEN, 1'b1, 8'h00);
    byte_io(8'hf4, 8'hff);
    for (int i = 0; i < 3; i++)
      byte_io(8'h00, 8'h28 + 8'(i * 16));
    op(OP_CLOSE, 1'b0, 8'h00);
    // unknown format is inert; seconds carry held then released by timeout
    op(OP_OPEN, 1'b0, 8'h00);
    pulse_carry();
    byte_io(8'h22, 8'hff);
    chk8(cy_cnt, 8'h00);
    byte_io(8'h55, 8'hff);
    byte_io(8'h28, 8'hff);
    byte_io(8'h66, 8'hff);
    chk8(cy_cnt, 8'h01);
    op(OP_CLOSE, 1'b0, 8'h00);
    chk8(regs[2], ival(2));
    chk8(wr_cnt, 8'h07);
    // carry held across a short session is released at close
    op(OP_OPEN, 1'b0, 8'h00);
    pulse_carry();
    chk8(cy_cnt, 8'h01);
    op(OP_CLOSE, 1'b0, 8'h00);
    chk8(cy_cnt, 8'h02);
    pulse_carry();
    @(negedge clk);
    chk8(cy_cnt, 8'h03);
    chk8(rv_cnt, 8'h15);
    report_and_stop();
  end
endmodule
